/* File: design/vos_map.vh */
`ifndef VOS_MAP_VH
`define VOS_MAP_VH
// Output signal types.
`define VOS_SIG_VOLT_NORM 2'h0
`define VOS_SIG_CUR_NORM 2'h1
`define VOS_SIG_VOLT_INV 2'h2
`define VOS_SIG_CUR_INV 2'h3
// Full scale and parameter limits in 0.01 % units; integrator time limit in ms.
`define VOS_FULL_SCALE 16'sh2710
`define VOS_MIN_LIMIT 16'sh1770
`define VOS_MAX_LOW 16'sh0BB8
`define VOS_TRIG_LIMIT 16'sh0FA0
`define VOS_OFFSET_LIMIT 16'sh0FA0
`define VOS_AV_LIMIT 16'sh07D0
`define VOS_DV_LIMIT 16'sh03E8
`define VOS_CR_LIMIT 16'sh01F4
`define VOS_ITIME_LIMIT 12'h7D0
// Reset values.
`define VOS_RST_MAX 16'sh2710
// Integrator tick: 1 ms at 125 MHz.
`define VOS_TICK_NS 1000000
`define VOS_CLK_NS 8
// DAC codes: volts in mV per pin, current in uA.
`define VOS_VOLT_FS 16'h2710
`define VOS_CUR_MID 16'h2EE0
`define VOS_CUR_SPAN 16'h1F40
`define VOS_CUR_MIN 16'h0FA0
`endif

/* File: design/vos_kink.v */
`timescale 1ns/10ps
`include "vos_map.vh"
// Kinked characteristic for one direction, magnitude in, magnitude out.
module vos_kink
(
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Shaping parameters.
  input wire [15:0] trig,
  input wire [15:0] floor_val,
  input wire [15:0] full_val,
  // Data.
  input wire [15:0] mag_in,
  output reg [15:0] mag_out
);

  reg [31:0] seg_num;
  reg [15:0] seg_den;
  reg [31:0] res;

  // Two linear segments meet at the trigger point; division is done in one
  // cycle, which costs area but keeps latency fixed.
  always @*
  begin
    seg_num = 32'h0;
    seg_den = 16'h1;
    res = 32'h0;
    if (mag_in == 16'h0)
      res = 32'h0;
    else if (mag_in <= trig)
    begin
      seg_num = mag_in * floor_val;
      seg_den = trig;
      res = seg_num / seg_den;
    end
    else if (trig >= `VOS_FULL_SCALE)
      res = {16'h0, full_val};
    else
    begin
      seg_num = (mag_in - trig) * (full_val - floor_val);
      seg_den = `VOS_FULL_SCALE - trig;
      res = floor_val + seg_num / seg_den;
    end
  end

  // Registered so the data output comes from a flip-flop.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mag_out <= 16'h0;
    else
      mag_out <= (res > 32'h2710) ? `VOS_FULL_SCALE : res[15:0];
  end

endmodule // vos_kink

/* File: design/vos_shaper.v */
`timescale 1ns/10ps
`include "vos_map.vh"
// Behaviour
// RL1 - Kinked shaping, per-direction floor and full scale
// RL2 - Two linear segments joined at trigger
// RL3 - Add signed zero correction to output
// RL4 - Four output types, voltage/current, both polarities
// RL5 - Voltage mode: 100 % gives 10 V
// RL6 - Current mode: 4..20 mA, 12 mA centre
// RL7 - Current below 4 mA disables output
// RL8 - Valve deactivates itself below 4 mA
// RL9 - Integrator runs below activation point
// RL10 - Integrator frozen below deactivation point
// RL11 - Activation point zero disables compensation
// RL12 - Integrator time sets integration rate
// RL13 - Compensation clamped to control range
// RL14 - Without fieldbus only activation point matters
// RL15 - Fieldbus enable bit gates compensation
// RL16 - Hold bit freezes static compensation
// RL17 - Fine positioning bit enables dynamic term
// RL18 - Static compensation done before dynamic
// RL19 - Limit should equal activation point
// RL20 - Sum after shaping, then saturate
module vos_shaper
#(
  parameter TICK_CYCLES = `VOS_TICK_NS / `VOS_CLK_NS
)
(
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Controller output, signed 0.01 % units.
  input wire [15:0] ctrl_in,
  // Shaping configuration.
  input wire [15:0] floor_a,
  input wire [15:0] floor_b,
  input wire [15:0] full_a,
  input wire [15:0] full_b,
  input wire [15:0] trig,
  input wire [15:0] zero_offset,
  input wire [1:0] signal_type,
  // Drift compensation configuration.
  input wire [15:0] drift_activation_point,
  input wire [15:0] drift_deactivation_point,
  input wire [11:0] drift_integrator_time,
  input wire [15:0] drift_integrator_limit,
  // Fieldbus control bits.
  input wire fieldbus_present,
  input wire drift_comp_enable_bit,
  input wire static_comp_hold_bit,
  input wire fine_pos_bit,
  // Valve command.
  output reg [15:0] out_pos_mv,
  output reg [15:0] out_neg_mv,
  output reg [15:0] out_cur_ua,
  output reg out_enable,
  output reg under_range_err,
  output reg [15:0] drift_comp_value
);

  // ------------------------------------------------------------
  // Parameter clamping
  // ------------------------------------------------------------
  wire [15:0] trig_c = (trig > `VOS_TRIG_LIMIT) ? `VOS_TRIG_LIMIT : trig;
  wire [15:0] fa_c = (floor_a > `VOS_MIN_LIMIT) ? `VOS_MIN_LIMIT : floor_a;
  wire [15:0] fb_c = (floor_b > `VOS_MIN_LIMIT) ? `VOS_MIN_LIMIT : floor_b;
  wire [15:0] ma_c = (full_a < `VOS_MAX_LOW) ? `VOS_MAX_LOW :
    ((full_a > `VOS_FULL_SCALE) ? `VOS_FULL_SCALE : full_a);
  wire [15:0] mb_c = (full_b < `VOS_MAX_LOW) ? `VOS_MAX_LOW :
    ((full_b > `VOS_FULL_SCALE) ? `VOS_FULL_SCALE : full_b);
  wire [15:0] av_c = (drift_activation_point > `VOS_AV_LIMIT) ? `VOS_AV_LIMIT
    : drift_activation_point;
  wire [15:0] dv_c = (drift_deactivation_point > `VOS_DV_LIMIT) ? `VOS_DV_LIMIT
    : drift_deactivation_point;
  wire [15:0] cr_c = (drift_integrator_limit > `VOS_CR_LIMIT) ? `VOS_CR_LIMIT
    : drift_integrator_limit;
  wire [11:0] it_c = (drift_integrator_time > `VOS_ITIME_LIMIT) ? `VOS_ITIME_LIMIT
    : drift_integrator_time;
  wire signed [17:0] off_s = $signed({{2{zero_offset[15]}}, zero_offset});
  wire signed [17:0] off_c = (off_s > 18'sd4000) ? 18'sd4000 :
    ((off_s < -18'sd4000) ? -18'sd4000 : off_s);

  // ------------------------------------------------------------
  // Direction split and kinked shaping
  // ------------------------------------------------------------
  wire neg_dir = ctrl_in[15];
  wire [15:0] mag = neg_dir ? (16'h0 - ctrl_in) : ctrl_in;
  wire [15:0] mag_lim = (mag > `VOS_FULL_SCALE) ? `VOS_FULL_SCALE : mag;
  wire [15:0] shaped_a;
  wire [15:0] shaped_b;
  reg neg_d_r;

  // One instance per direction so each keeps its own floor and full scale.
  vos_kink u_kink_a
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .trig(trig_c),
    .floor_val(fa_c),
    .full_val(ma_c),
    .mag_in(neg_dir ? 16'h0 : mag_lim),
    .mag_out(shaped_a)
  ); // RL1 RL2
  vos_kink u_kink_b
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .trig(trig_c),
    .floor_val(fb_c),
    .full_val(mb_c),
    .mag_in(neg_dir ? mag_lim : 16'h0),
    .mag_out(shaped_b)
  ); // RL1 RL2

  // Direction is delayed to line up with the registered kink outputs.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      neg_d_r <= 1'b0;
    else
      neg_d_r <= neg_dir;
  end

  wire signed [17:0] shaped_s = neg_d_r ? -$signed({2'b00, shaped_b})
    : $signed({2'b00, shaped_a});

  // ------------------------------------------------------------
  // Drift compensation integrator
  // ------------------------------------------------------------
  reg [17:0] tick_cnt_r;
  reg tick_r;
  reg [11:0] rate_cnt_r;
  reg signed [15:0] integ_r;
  reg signed [15:0] integ_nxt;
  wire signed [17:0] cr_s = $signed({2'b00, cr_c});
  wire [15:0] abs_ctrl = mag_lim;
  // Combined function without fieldbus; with fieldbus the enable bit gates it.
  wire dc_on = (av_c != 16'h0) &&
    (!fieldbus_present || drift_comp_enable_bit); // RL11 RL14 RL15
  // With fieldbus the hold bit freezes the static term unless fine
  // positioning asks for the dynamic term to keep tracking.
  wire dc_hold = fieldbus_present && static_comp_hold_bit && !fine_pos_bit; // RL16 RL17
  wire in_active = abs_ctrl < av_c; // RL9
  wire in_dead = abs_ctrl < dv_c; // RL10

  // 1 ms tick from the system clock.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 18'h0;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == TICK_CYCLES[17:0] - 18'h1)
    begin
      tick_cnt_r <= 18'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 18'h1;
      tick_r <= 1'b0;
    end
  end

  // Integrator takes one 0.01 % step every integrator-time plus one milliseconds, so a
  // shorter time compensates faster. Step sign follows the controller output.
  always @*
  begin
    integ_nxt = integ_r;
    if (!dc_on)
      integ_nxt = 16'sh0;
    else if (tick_r && (rate_cnt_r >= it_c) && in_active && !in_dead && !dc_hold)
    begin
      if (neg_dir)
        integ_nxt = integ_r - 16'sh1;
      else
        integ_nxt = integ_r + 16'sh1;
    end // RL9 RL10 RL12
    if ($signed({{2{integ_nxt[15]}}, integ_nxt}) > cr_s)
      integ_nxt = cr_c;
    else if ($signed({{2{integ_nxt[15]}}, integ_nxt}) < -cr_s)
      integ_nxt = 16'h0 - cr_c; // RL13
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      integ_r <= 16'sh0;
      rate_cnt_r <= 12'h0;
    end
    else
    begin
      integ_r <= integ_nxt;
      if (tick_r)
        rate_cnt_r <= (rate_cnt_r >= it_c) ? 12'h0 : rate_cnt_r + 12'h1;
    end
  end

  // ------------------------------------------------------------
  // Summation, saturation and signal conversion
  // ------------------------------------------------------------
  wire signed [17:0] sum_s = shaped_s + off_c +
    $signed({{2{integ_r[15]}}, integ_r}); // RL3 RL20
  wire signed [17:0] sat_s = (sum_s > 18'sd10000) ? 18'sd10000 :
    ((sum_s < -18'sd10000) ? -18'sd10000 : sum_s); // RL20
  wire inv = signal_type[1]; // RL4
  wire signed [17:0] pol_s = inv ? -sat_s : sat_s;
  // Each pin swings 0..10 V around a 5 V midpoint: differential = 2 x half.
  wire signed [17:0] half_v = pol_s >>> 1;
  wire [17:0] vpos = 18'd5000 + half_v;
  wire [17:0] vneg = 18'd5000 - half_v;
  wire [31:0] cur_prod = $signed({{14{pol_s[17]}}, pol_s}) * 32'sd8000;
  wire signed [31:0] cur_dev = $signed(cur_prod) / 32'sd10000;
  wire [31:0] cur_code = 32'd12000 + cur_dev;
  wire cur_mode = signal_type[0];
  // Anything below 4 mA would be nonsense to the valve; treat it as a fault.
  wire cur_low = cur_mode && (cur_code[31] || (cur_code < {16'h0, `VOS_CUR_MIN}));

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_pos_mv <= 16'h0;
      out_neg_mv <= 16'h0;
      out_cur_ua <= 16'h0;
      out_enable <= 1'b0;
      under_range_err <= 1'b0;
      drift_comp_value <= 16'h0;
    end
    else
    begin
      drift_comp_value <= integ_r;
      under_range_err <= cur_low; // RL7
      out_enable <= !cur_low; // RL7 RL8
      if (cur_mode)
      begin
        out_pos_mv <= 16'h0;
        out_neg_mv <= 16'h0;
        out_cur_ua <= cur_low ? 16'h0 : cur_code[15:0]; // RL6
      end
      else
      begin
        out_pos_mv <= vpos[15:0]; // RL5
        out_neg_mv <= vneg[15:0]; // RL5
        out_cur_ua <= 16'h0;
      end
    end
  end

endmodule // vos_shaper

/* File: bench/vos_shaper_sva.sv */
`timescale 1ns/10ps
// ----
// Output and drift checker
// ----
module vos_shaper_sva (
  // Clock and reset.
  input logic clk_sys,
  input logic rst,
  // Configuration.
  input logic [1:0] signal_type,
  input logic [15:0] drift_activation_point,
  input logic [15:0] drift_integrator_limit,
  input logic fieldbus_present,
  input logic drift_comp_enable_bit,
  input logic static_comp_hold_bit,
  input logic fine_pos_bit,
  // Valve command.
  input logic [15:0] out_pos_mv,
  input logic [15:0] out_neg_mv,
  input logic [15:0] out_cur_ua,
  input logic out_enable,
  input logic under_range_err,
  input logic [15:0] drift_comp_value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A limit above 500 still clamps at 500.
  wire [15:0] mag = drift_comp_value[15] ? -drift_comp_value : drift_comp_value;
  wire [15:0] lim = drift_integrator_limit > 16'h01F4 ? 16'h01F4 : drift_integrator_limit;
  wire hold = fieldbus_present && drift_comp_enable_bit && static_comp_hold_bit;
  sequence s_volt; (!signal_type[0]) [*3]; endsequence
  sequence s_cur; (signal_type[0]) [*3]; endsequence
  sequence s_hold; (hold && !fine_pos_bit) [*3]; endsequence
  volt_no_cur_a: assert property (s_volt |-> out_cur_ua == 16'h0000)
    else $error("current driven in voltage mode");
  volt_sum_a: assert property (s_volt ##0 out_enable |->
    (out_pos_mv + out_neg_mv) inside {[16'h270F:16'h2711]}) else $error("pin sum off");
  cur_no_volt_a: assert property (s_cur |-> out_pos_mv == 0 && out_neg_mv == 0)
    else $error("voltage driven in current mode");
  cur_span_a: assert property (s_cur ##0 out_enable |->
    out_cur_ua inside {[16'h0FA0:16'h4E20]}) else $error("current outside span");
  err_off_a: assert property (under_range_err |-> !out_enable)
    else $error("output enabled under error");
  drift_clamp_a: assert property ($stable(lim) [*3] |-> mag <= lim)
    else $error("drift value beyond limit");
  drift_off_a: assert property ((drift_activation_point == 0) [*3] |-> mag == 0)
    else $error("drift runs while disabled");
  bus_gate_a: assert property ((fieldbus_present && !drift_comp_enable_bit) [*3] |->
    mag == 0) else $error("drift runs without enable");
  hold_a: assert property (s_hold |-> $stable(drift_comp_value))
    else $error("drift moved while held");
  step_a: assert property ($changed(drift_comp_value) |-> mag == 0 ||
    (drift_comp_value - $past(drift_comp_value)) inside {16'h0001, 16'hFFFF})
    else $error("drift step larger than one");
endmodule // vos_shaper_sva

bind vos_shaper vos_shaper_sva u_sva (.clk_sys, .rst, .signal_type, .drift_activation_point,
  .drift_integrator_limit, .fieldbus_present, .drift_comp_enable_bit, .static_comp_hold_bit,
  .fine_pos_bit, .out_pos_mv, .out_neg_mv, .out_cur_ua, .out_enable, .under_range_err,
  .drift_comp_value);

/* File: bench/vos_valve_model.sv */
`timescale 1ns/10ps
// ----
// Valve amplifier input
// ----
module vos_valve_model (
  // Pins from the module.
  input logic [15:0] pin_pos_mv,
  input logic [15:0] pin_neg_mv,
  input logic [15:0] pin_cur_ua,
  // Wiring choice, current loop when bit 0 is high.
  input logic [1:0] signal_type,
  // Decoded command in 0.01 % units.
  output logic valve_active,
  output logic signed [31:0] valve_cmd
);
  // A loop current below 4 mA shuts the valve, so a dead module leaves it safe.
  always @*
  begin
    if (signal_type[0])
    begin
      valve_active = pin_cur_ua >= 16'h0FA0;
      valve_cmd = valve_active ? ($signed({16'h0000, pin_cur_ua}) - 12000) * 5 / 4 : 0;
    end
    else
    begin
      valve_active = 1'b1;
      valve_cmd = $signed({16'h0000, pin_pos_mv}) - $signed({16'h0000, pin_neg_mv});
    end
  end
endmodule // vos_valve_model

/* File: bench/test_valve_output_shaping_drift_comp.sv */
`timescale 1ns/10ps
// ----
// Testbench
// ----
module test_valve_output_shaping_drift_comp;
  logic clk_sys = 1'b0, rst = 1'b1, fb = 1'b0, en = 1'b0, hold = 1'b0, fine = 1'b0;
  logic [15:0] ctrl_in = 0, floor_a = 0, floor_b = 0, full_a = 16'h2710, full_b = 16'h2710;
  logic [15:0] trig = 0, zero_offset = 0, av = 0, dv = 0, lim = 0;
  logic [11:0] itime = 0;
  logic [1:0] sig = 0;
  wire [15:0] pos_mv, neg_mv, cur_ua, dcv;
  wire out_en, err, v_act;
  wire signed [31:0] v_cmd;
  int fails = 0, n_compared = 0, cyc = 0;

  // Short tick keeps the integrator tests to a few hundred cycles.
  vos_shaper #(.TICK_CYCLES(10)) DUT (.clk_sys, .rst, .ctrl_in, .floor_a, .floor_b,
    .full_a, .full_b, .trig, .zero_offset, .signal_type(sig), .drift_activation_point(av),
    .drift_deactivation_point(dv), .drift_integrator_time(itime),
    .drift_integrator_limit(lim), .fieldbus_present(fb), .drift_comp_enable_bit(en),
    .static_comp_hold_bit(hold), .fine_pos_bit(fine), .out_pos_mv(pos_mv),
    .out_neg_mv(neg_mv), .out_cur_ua(cur_ua), .out_enable(out_en), .under_range_err(err),
    .drift_comp_value(dcv));
  vos_valve_model u_valve (.pin_pos_mv(pos_mv), .pin_neg_mv(neg_mv), .pin_cur_ua(cur_ua),
    .signal_type(sig), .valve_active(v_act), .valve_cmd(v_cmd));

  // Clock and hang guard.
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict;
    end
  end

  // Compare tasks; rounding of the scaling may differ by a count or two.
  task chk(input string n, input logic signed [31:0] e, g, input int t);
    n_compared++;
    if ($isunknown(g) || g > e + t || g < e - t)
    begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task chkb(input string n, input logic e, g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task run(input int c, n);
    ctrl_in <= c[15:0];
    repeat (n) @(posedge clk_sys);
  endtask
  task out(input int c, e);
    run(c, 4);
    chk("valve_cmd", e, v_cmd, 2);
  endtask
  function int kink(int x, tr, fl, fu);
    if (x <= tr) return tr == 0 ? 0 : x * fl / tr;
    return fl + (x - tr) * (fu - fl) / (10000 - tr);
  endfunction
  task give_verdict;
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    run(5000, 3);
    chk("pin_pos", 7500, pos_mv, 0);
    chk("pin_neg", 2500, neg_mv, 0);
    floor_a <= 16'h0FA0;
    floor_b <= 16'h07D0;
    full_a <= 16'h1F40;
    trig <= 16'h03E8;
    out(500, kink(500, 1000, 4000, 8000));
    out(1000, 4000);
    out(5500, kink(5500, 1000, 4000, 8000));
    out(10000, 8000);
    out(-1000, -2000);
    out(-10000, -10000);
    floor_a <= 16'h1B58;
    out(1000, 6000);
    floor_a <= 0;
    floor_b <= 0;
    full_a <= 16'h2710;
    trig <= 0;
    zero_offset <= 16'h012C;
    out(0, 300);
    zero_offset <= 16'h1388;
    out(0, 4000);
    zero_offset <= 16'hF060;
    out(-10000, -10000);
    zero_offset <= 0;
    for (int t = 0; t < 4; t++)
    begin
      sig <= t[1:0];
      out(5000, t[1] ? -5000 : 5000);
      chk("cur_ua", t[0] ? (t[1] ? 8000 : 16000) : 0, cur_ua, 0);
      chkb("valve_active", 1'b1, v_act);
      chkb("out_enable", 1'b1, out_en);
      chkb("under_range", 1'b0, err);
    end
    sig <= 2'h1;
    out(-10000, -10000);
    sig <= 0;
    av <= 16'h07D0;
    dv <= 16'h0064;
    lim <= 16'h0003;
    run(500, 100);
    chk("drift", 3, dcv, 0);
    chk("valve_cmd", 503, v_cmd, 1);
    run(50, 60);
    chk("drift", 3, dcv, 0);
    run(-500, 100);
    chk("drift", -3, $signed(dcv), 0);
    av <= 0;
    run(500, 5);
    chk("drift", 0, dcv, 0);
    // Control range set equal to the activation point, as recommended.
    av <= 16'h01F4;
    lim <= 16'h01F4;
    itime <= 12'h004;
    run(400, 230);
    chk("drift", 4, dcv, 1);
    fb <= 1'b1;
    run(500, 10);
    chk("drift", 0, dcv, 0);
    lim <= 16'h0003;
    av <= 16'h07D0;
    itime <= 0;
    en <= 1'b1;
    run(500, 60);
    chk("drift", 3, dcv, 0);
    hold <= 1'b1;
    run(-500, 60);
    chk("drift", 3, dcv, 0);
    fine <= 1'b1;
    run(-500, 100);
    chk("drift", -3, $signed(dcv), 0);
    {fb, en, hold, fine} <= 4'h0;
    run(500, 100);
    chk("drift", 3, dcv, 0);
    give_verdict;
  end
endmodule // test_valve_output_shaping_drift_comp
